// File: src/ttcu_top.sv
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ttcu_top
    import ttcu_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // External pins
    input wire logic t0_count_pin,
    input wire logic t1_count_pin,
    input wire logic t2_count_pin,
    input wire logic t2_trigger_pin,
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    // Interrupt requests
    output logic t0_irq_req,
    output logic t1_irq_req,
    output logic t2_irq_req,
    // Overflow and baud ticks
    output logic t1_overflow_pulse,
    output logic t2_overflow_pulse,
    output logic uart1_rx_baud_tick,
    output logic uart1_tx_baud_tick,
    output logic uart2_rx_baud_tick,
    output logic uart2_tx_baud_tick
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_PINS-1:0] pin_s1;
        logic [NUM_PINS-1:0] pin_s2;
        logic [NUM_PINS-1:0] pin_s3;
        logic t1_overflow_flag;
        logic t1_run_bit;
        logic t0_overflow_flag;
        logic t0_run_bit;
        logic [7:0] timer_mode;
        logic [7:0] t0_low_byte;
        logic [7:0] t0_high_byte;
        logic [7:0] t1_low_byte;
        logic [7:0] t1_high_byte;
        logic [7:0] timer2_control;
        logic uart2_rx_clock_sel;
        logic uart2_tx_clock_sel;
        logic [7:0] capture_reload_low;
        logic [7:0] capture_reload_high;
        logic [7:0] t2_low_byte;
        logic [7:0] t2_high_byte;
        logic [7:0] rdata;
        logic t1_ovf_p;
        logic t2_ovf_p;
        logic [3:0] baud_p;
    } ttcu_state_s;

    ttcu_state_s st_reg;
    ttcu_state_s st_next;

    // One count step of timer 0 or 1, result is {overflow, high, low}.
    function automatic logic [16:0] t01_step(input logic [1:0] mode,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
        logic [16:0] res;
        res = {1'b0, hi, lo};
        case (mode)
            MODE_13BIT: begin
                // Upper three low bits are left as they are.
                if (lo[4:0] == 5'h1f) begin
                    res[16] = (hi == 8'hff);
                    res[15:8] = hi + 8'h01;
                    res[7:0] = {lo[7:5], 5'h00};
                end else begin
                    res[7:0] = {lo[7:5], lo[4:0] + 5'h01};
                end
            end
            MODE_16BIT: begin
                res[16] = ({hi, lo} == 16'hffff);
                res[15:0] = {hi, lo} + 16'h0001;
            end
            MODE_RELOAD: begin
                if (lo == 8'hff) begin
                    res[16] = 1'b1;
                    res[7:0] = hi;
                end else begin
                    res[7:0] = lo + 8'h01;
                end
            end
            default: begin
                res[16] = 1'b0;
            end
        endcase
        return res;
    endfunction

    // ------------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_fall;
    logic [NUM_PINS-1:0] pin_lvl;
    logic [1:0] t0_mode;
    logic [1:0] t1_mode;
    logic t0_split;
    logic t0_en;
    logic t1_en;
    logic t0h_en;
    logic t2_baud;
    logic t2_en;
    logic t2_ovf;
    logic t2_trig;
    logic [16:0] t0_res;
    logic [16:0] t1_res;

    assign pin_lvl = st_reg.pin_s2;
    assign pin_fall = st_reg.pin_s3 & ~st_reg.pin_s2;
    assign t0_mode = st_reg.timer_mode[NIB_T0+1:NIB_T0];
    assign t1_mode = st_reg.timer_mode[NIB_T1+1:NIB_T1];
    assign t0_split = (t0_mode == MODE_SPLIT);
    // Gate qualification and counter-select for timer 0.
    assign t0_en = st_reg.t0_run_bit
        && (!st_reg.timer_mode[NIB_T0+NIB_GATE] || pin_lvl[PIN_IRQA])
        && (!st_reg.timer_mode[NIB_T0+NIB_CT] || pin_fall[PIN_T0]);
    // While timer 0 is split, timer 1 runs unless parked in its mode 3.
    assign t1_en = (st_reg.t1_run_bit || t0_split)
        && (!st_reg.timer_mode[NIB_T1+NIB_GATE] || pin_lvl[PIN_IRQB])
        && (!st_reg.timer_mode[NIB_T1+NIB_CT] || pin_fall[PIN_T1])
        && (t1_mode != MODE_SPLIT);
    assign t0h_en = t0_split && st_reg.t1_run_bit;
    assign t0_res = t01_step(t0_mode, st_reg.t0_low_byte,
                             st_reg.t0_high_byte);
    assign t1_res = t01_step(t1_mode, st_reg.t1_low_byte,
                             st_reg.t1_high_byte);
    assign t2_baud = st_reg.timer2_control[T2_RCLK]
        || st_reg.timer2_control[T2_UART1_TX_CLOCK_SEL]
        || st_reg.uart2_rx_clock_sel || st_reg.uart2_tx_clock_sel;
    assign t2_en = st_reg.timer2_control[T2_TR]
        && (!st_reg.timer2_control[T2_CT] || pin_fall[PIN_T2]);
    assign t2_ovf = t2_en
        && ({st_reg.t2_high_byte, st_reg.t2_low_byte} == 16'hffff);
    assign t2_trig = st_reg.timer2_control[T2_EXEN] && !t2_baud
        && pin_fall[PIN_TRIG];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic t1_ovf;
        logic [15:0] t2_cnt;
        t1_ovf = 1'b0;
        t2_cnt = {st_reg.t2_high_byte, st_reg.t2_low_byte};
        st_next = st_reg;
        st_next.pin_s1 = {ext_irq_pin_b, ext_irq_pin_a, t2_trigger_pin,
                          t2_count_pin, t1_count_pin, t0_count_pin};
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.pin_s3 = st_reg.pin_s2;
        // Software writes land first; hardware flag sets win below.
        if (reg_wr) begin
            if (reg_addr == ADDR_TIMER_CONTROL_REG) begin
                st_next.t1_overflow_flag = reg_wdata[TC_TF1];
                st_next.t1_run_bit = reg_wdata[TC_TR1];
                st_next.t0_overflow_flag = reg_wdata[TC_TF0];
                st_next.t0_run_bit = reg_wdata[TC_TR0];
            end else if (reg_addr == ADDR_TIMER_MODE_REG) begin
                st_next.timer_mode = reg_wdata;
            end else if (reg_addr == ADDR_TIMER2_CONTROL) begin
                st_next.timer2_control = reg_wdata;
            end else if (reg_addr == ADDR_U2SEL) begin
                st_next.uart2_rx_clock_sel = reg_wdata[U2_RX];
                st_next.uart2_tx_clock_sel = reg_wdata[U2_TX];
            end else if (reg_addr == ADDR_CAP_LO) begin
                st_next.capture_reload_low = reg_wdata;
            end else if (reg_addr == ADDR_CAP_HI) begin
                st_next.capture_reload_high = reg_wdata;
            end
        end
        // Timer 0, either whole or split into two 8-bit halves.
        if (t0_split) begin
            if (t0_en) begin
                st_next.t0_low_byte = st_reg.t0_low_byte + 8'h01;
                if (st_reg.t0_low_byte == 8'hff) begin
                    st_next.t0_overflow_flag = 1'b1;
                end
            end
            if (t0h_en) begin
                st_next.t0_high_byte = st_reg.t0_high_byte + 8'h01;
                if (st_reg.t0_high_byte == 8'hff) begin
                    st_next.t1_overflow_flag = 1'b1;
                end
            end
        end else if (t0_en) begin
            st_next.t0_high_byte = t0_res[15:8];
            st_next.t0_low_byte = t0_res[7:0];
            if (t0_res[16]) begin
                st_next.t0_overflow_flag = 1'b1;
            end
        end
        // Timer 1 keeps ticking the UART even without its flag.
        if (t1_en) begin
            st_next.t1_high_byte = t1_res[15:8];
            st_next.t1_low_byte = t1_res[7:0];
            t1_ovf = t1_res[16];
            if (t1_res[16] && !t0_split) begin
                st_next.t1_overflow_flag = 1'b1;
            end
        end
        // Timer 2 count, rollover and trigger events.
        if (t2_en) begin
            if (t2_ovf) begin
                if (t2_baud || !st_reg.timer2_control[T2_CPRL]) begin
                    t2_cnt = {st_reg.capture_reload_high,
                              st_reg.capture_reload_low};
                end else begin
                    t2_cnt = 16'h0000;
                end
            end else begin
                t2_cnt = t2_cnt + 16'h0001;
            end
        end
        if (t2_trig) begin
            if (st_reg.timer2_control[T2_CPRL]) begin
                st_next.capture_reload_low = st_reg.t2_low_byte;
                st_next.capture_reload_high = st_reg.t2_high_byte;
            end else begin
                t2_cnt = {st_reg.capture_reload_high,
                          st_reg.capture_reload_low};
            end
        end
        st_next.t2_high_byte = t2_cnt[15:8];
        st_next.t2_low_byte = t2_cnt[7:0];
        // Count-byte writes override the count step of the same cycle.
        if (reg_wr) begin
            if (reg_addr == ADDR_T0_LO) begin
                st_next.t0_low_byte = reg_wdata;
            end else if (reg_addr == ADDR_T0_HI) begin
                st_next.t0_high_byte = reg_wdata;
            end else if (reg_addr == ADDR_T1_LO) begin
                st_next.t1_low_byte = reg_wdata;
            end else if (reg_addr == ADDR_T1_HI) begin
                st_next.t1_high_byte = reg_wdata;
            end else if (reg_addr == ADDR_T2_LO) begin
                st_next.t2_low_byte = reg_wdata;
            end else if (reg_addr == ADDR_T2_HI) begin
                st_next.t2_high_byte = reg_wdata;
            end
        end
        if (t2_ovf && !t2_baud) begin
            st_next.timer2_control[T2_TF] = 1'b1;
        end
        if (t2_trig) begin
            st_next.timer2_control[T2_EXF] = 1'b1;
        end
        st_next.t1_ovf_p = t1_ovf;
        st_next.t2_ovf_p = t2_ovf;
        st_next.baud_p = {
            st_reg.timer2_control[T2_RCLK] ? t2_ovf : t1_ovf,
            st_reg.timer2_control[T2_UART1_TX_CLOCK_SEL] ? t2_ovf : t1_ovf,
            st_reg.uart2_rx_clock_sel ? t2_ovf : t1_ovf,
            st_reg.uart2_tx_clock_sel ? t2_ovf : t1_ovf};
        // Read data stand only in the cycle after the strobe.
        st_next.rdata = RST_BYTE;
        if (reg_rd) begin
            if (reg_addr == ADDR_TIMER_CONTROL_REG) begin
                st_next.rdata = {st_reg.t1_overflow_flag, st_reg.t1_run_bit,
                                 st_reg.t0_overflow_flag, st_reg.t0_run_bit,
                                 4'h0};
            end else if (reg_addr == ADDR_TIMER_MODE_REG) begin
                st_next.rdata = st_reg.timer_mode;
            end else if (reg_addr == ADDR_T0_LO) begin
                st_next.rdata = st_reg.t0_low_byte;
            end else if (reg_addr == ADDR_T0_HI) begin
                st_next.rdata = st_reg.t0_high_byte;
            end else if (reg_addr == ADDR_T1_LO) begin
                st_next.rdata = st_reg.t1_low_byte;
            end else if (reg_addr == ADDR_T1_HI) begin
                st_next.rdata = st_reg.t1_high_byte;
            end else if (reg_addr == ADDR_TIMER2_CONTROL) begin
                st_next.rdata = st_reg.timer2_control;
            end else if (reg_addr == ADDR_U2SEL) begin
                st_next.rdata = {2'h0, st_reg.uart2_rx_clock_sel,
                                 st_reg.uart2_tx_clock_sel, 4'h0};
            end else if (reg_addr == ADDR_CAP_LO) begin
                st_next.rdata = st_reg.capture_reload_low;
            end else if (reg_addr == ADDR_CAP_HI) begin
                st_next.rdata = st_reg.capture_reload_high;
            end else if (reg_addr == ADDR_T2_LO) begin
                st_next.rdata = st_reg.t2_low_byte;
            end else if (reg_addr == ADDR_T2_HI) begin
                st_next.rdata = st_reg.t2_high_byte;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata = st_reg.rdata;
    assign t0_irq_req = st_reg.t0_overflow_flag;
    assign t1_irq_req = st_reg.t1_overflow_flag;
    assign t2_irq_req = st_reg.timer2_control[T2_TF]
        || st_reg.timer2_control[T2_EXF];
    assign t1_overflow_pulse = st_reg.t1_ovf_p;
    assign t2_overflow_pulse = st_reg.t2_ovf_p;
    assign uart1_rx_baud_tick = st_reg.baud_p[3];
    assign uart1_tx_baud_tick = st_reg.baud_p[2];
    assign uart2_rx_baud_tick = st_reg.baud_p[1];
    assign uart2_tx_baud_tick = st_reg.baud_p[0];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic wr_t0;
    logic wr_t1;
    logic wr_t2;
    assign wr_t0 = reg_wr
        && (reg_addr == ADDR_T0_LO || reg_addr == ADDR_T0_HI);
    assign wr_t1 = reg_wr
        && (reg_addr == ADDR_T1_LO || reg_addr == ADDR_T1_HI);
    assign wr_t2 = reg_wr
        && (reg_addr == ADDR_T2_LO || reg_addr == ADDR_T2_HI);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_t2_capture_trig;
        t2_trig && st_reg.timer2_control[T2_CPRL];
    endsequence
    sequence s_t2_rollover;
        t2_ovf && !t2_trig && !wr_t2;
    endsequence

    property p_t0_carry;
        t0_en && !t0_split && t0_mode == MODE_13BIT && !wr_t0
            && st_reg.t0_low_byte[4:0] == 5'h1f
        |=> st_reg.t0_low_byte[4:0] == 5'h00
            && st_reg.t0_high_byte == $past(st_reg.t0_high_byte) + 8'h01;
    endproperty
    a_t0_carry: assert property (p_t0_carry)
        else $error("Mode 0 prescaler carry wrong.");
    property p_t1_flag;
        t1_en && t1_res[16] && !t0_split |=> st_reg.t1_overflow_flag;
    endproperty
    a_t1_flag: assert property (p_t1_flag)
        else $error("Timer 1 overflow flag not set.");
    property p_t0_gate;
        st_reg.t0_run_bit && st_reg.timer_mode[NIB_T0+NIB_GATE]
            && !pin_lvl[PIN_IRQA] && !t0_split && !wr_t0
        |=> $stable(st_reg.t0_low_byte) && $stable(st_reg.t0_high_byte);
    endproperty
    a_t0_gate: assert property (p_t0_gate)
        else $error("Timer 0 counted while gated off.");
    property p_run_keeps;
        reg_wr && reg_addr == ADDR_TIMER_CONTROL_REG && !t0_en && !t0h_en
        |=> $stable(st_reg.t0_low_byte) && $stable(st_reg.t0_high_byte);
    endproperty
    a_run_keeps: assert property (p_run_keeps)
        else $error("Run bit write disturbed the count.");
    property p_t1_m1;
        t1_en && t1_mode == MODE_16BIT && !wr_t1
        |=> {st_reg.t1_high_byte, st_reg.t1_low_byte}
            == $past({st_reg.t1_high_byte, st_reg.t1_low_byte}) + 16'h0001;
    endproperty
    a_t1_m1: assert property (p_t1_m1)
        else $error("Mode 1 count step wrong.");
    property p_t1_reload;
        t1_en && t1_mode == MODE_RELOAD && st_reg.t1_low_byte == 8'hff
            && !wr_t1
        |=> st_reg.t1_low_byte == st_reg.t1_high_byte
            && $stable(st_reg.t1_high_byte);
    endproperty
    a_t1_reload: assert property (p_t1_reload)
        else $error("Mode 2 reload wrong.");
    property p_t1_hold;
        (t1_mode == MODE_SPLIT && !wr_t1) [*2]
        |=> $stable(st_reg.t1_low_byte) && $stable(st_reg.t1_high_byte);
    endproperty
    a_t1_hold: assert property (p_t1_hold)
        else $error("Timer 1 in mode 3 did not hold.");
    property p_t2_stop;
        !st_reg.timer2_control[T2_TR] && !t2_trig && !wr_t2
        |=> $stable(st_reg.t2_low_byte) && $stable(st_reg.t2_high_byte);
    endproperty
    a_t2_stop: assert property (p_t2_stop)
        else $error("Timer 2 counted while stopped.");
    property p_t2_capture;
        s_t2_capture_trig
        |=> st_reg.capture_reload_low == $past(st_reg.t2_low_byte)
            && st_reg.capture_reload_high == $past(st_reg.t2_high_byte)
            && st_reg.timer2_control[T2_EXF];
    endproperty
    a_t2_capture: assert property (p_t2_capture)
        else $error("Timer 2 capture wrong.");
    property p_t2_reload;
        s_t2_rollover ##0 (t2_baud || !st_reg.timer2_control[T2_CPRL])
        |=> st_reg.t2_low_byte == $past(st_reg.capture_reload_low)
            && st_reg.t2_high_byte == $past(st_reg.capture_reload_high)
            && t2_overflow_pulse;
    endproperty
    a_t2_reload: assert property (p_t2_reload)
        else $error("Timer 2 auto-reload wrong.");
    property p_t2_baud_flag;
        t2_baud && !(reg_wr && reg_addr == ADDR_TIMER2_CONTROL)
        |=> $stable(st_reg.timer2_control[T2_TF]);
    endproperty
    a_t2_baud_flag: assert property (p_t2_baud_flag)
        else $error("Overflow flag set in baud mode.");
    property p_baud_tick;
        t2_ovf && st_reg.timer2_control[T2_UART1_TX_CLOCK_SEL]
        |=> uart1_tx_baud_tick && t2_overflow_pulse;
    endproperty
    a_baud_tick: assert property (p_baud_tick)
        else $error("UART 1 transmit tick missing.");
    property p_t0_split_hi;
        t0h_en && !wr_t0
        |=> st_reg.t0_high_byte == $past(st_reg.t0_high_byte) + 8'h01;
    endproperty
    a_t0_split_hi: assert property (p_t0_split_hi)
        else $error("Split high byte did not step.");
    property p_t2_trig_reload;
        t2_trig && !st_reg.timer2_control[T2_CPRL] && !wr_t2
        |=> st_reg.t2_low_byte == $past(st_reg.capture_reload_low)
            && st_reg.t2_high_byte == $past(st_reg.capture_reload_high)
            && st_reg.timer2_control[T2_EXF];
    endproperty
    a_t2_trig_reload: assert property (p_t2_trig_reload)
        else $error("Trigger reload wrong.");
endmodule
`default_nettype wire

// File: inc/ttcu_pkg.sv
package ttcu_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_TIMER_CONTROL_REG = 4'h0;
    localparam logic [3:0] ADDR_TIMER_MODE_REG = 4'h1;
    localparam logic [3:0] ADDR_T0_LO = 4'h2;
    localparam logic [3:0] ADDR_T0_HI = 4'h3;
    localparam logic [3:0] ADDR_T1_LO = 4'h4;
    localparam logic [3:0] ADDR_T1_HI = 4'h5;
    localparam logic [3:0] ADDR_TIMER2_CONTROL = 4'h6;
    localparam logic [3:0] ADDR_U2SEL = 4'h7;
    localparam logic [3:0] ADDR_CAP_LO = 4'h8;
    localparam logic [3:0] ADDR_CAP_HI = 4'h9;
    localparam logic [3:0] ADDR_T2_LO = 4'ha;
    localparam logic [3:0] ADDR_T2_HI = 4'hb;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TC_TF1 = 7;
    localparam int TC_TR1 = 6;
    localparam int TC_TF0 = 5;
    localparam int TC_TR0 = 4;
    localparam int NIB_T0 = 0;
    localparam int NIB_T1 = 4;
    localparam int NIB_GATE = 3;
    localparam int NIB_CT = 2;
    localparam int T2_TF = 7;
    localparam int T2_EXF = 6;
    localparam int T2_RCLK = 5;
    localparam int T2_UART1_TX_CLOCK_SEL = 4;
    localparam int T2_EXEN = 3;
    localparam int T2_TR = 2;
    localparam int T2_CT = 1;
    localparam int T2_CPRL = 0;
    localparam int U2_RX = 5;
    localparam int U2_TX = 4;
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    // ------------------------------------------------------------------
    // Pin indices and reset value
    // ------------------------------------------------------------------
    localparam int PIN_T0 = 0;
    localparam int PIN_T1 = 1;
    localparam int PIN_T2 = 2;
    localparam int PIN_TRIG = 3;
    localparam int PIN_IRQA = 4;
    localparam int PIN_IRQB = 5;
    localparam int NUM_PINS = 6;
    localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// File: testbench/ttcu_pins.sv
`timescale 1ns/10ps
`default_nettype none
module ttcu_pins (
    // Bench side
    input wire logic core_clk,
    input wire logic [5:0] level,
    // Pin side
    output logic [5:0] pins
);
    logic [5:0] pins_reg = 6'h3f;
    always_ff @(posedge core_clk) pins_reg <= level;
    assign pins = pins_reg;
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top import ttcu_pkg::*; ;
    logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
    logic [5:0] level = 6'h3f, pins;
    logic [2:0] evt;
    int mismatches = 0, cmp_count = 0;
    initial forever #5 core_clk = ~core_clk;
    ttcu_pins ttcu_pins_i (.core_clk(core_clk), .level(level), .pins(pins));
    ttcu_top ttcu_top_i (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .t0_count_pin(pins[PIN_T0]),
        .t1_count_pin(pins[PIN_T1]), .t2_count_pin(pins[PIN_T2]),
        .t2_trigger_pin(pins[PIN_TRIG]), .ext_irq_pin_a(pins[PIN_IRQA]),
        .ext_irq_pin_b(pins[PIN_IRQB]), .t0_irq_req(evt[0]), .t1_irq_req(),
        .t2_irq_req(evt[1]), .t1_overflow_pulse(), .t2_overflow_pulse(),
        .uart1_rx_baud_tick(), .uart1_tx_baud_tick(evt[2]),
        .uart2_rx_baud_tick(), .uart2_tx_baud_tick());
    task automatic stop_test(input int bad);
        mismatches += bad;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] x);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 cmp_count++;
        if (reg_rdata !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, reg_rdata, e);
        end
    endtask
    task automatic wt(input int k);
        for (int i = 0; i < 3000 && (i == 0 || evt[k] !== 1'b1); i++)
            @(negedge core_clk);
        if (evt[k] !== 1'b1) begin
            $display("BAD t=%0t got=%h exp=%h", $time, evt[k], 1'b1);
            stop_test(1);
        end
    endtask
    function automatic logic [7:0] hi_after(input int m, input logic [7:0] h);
        return (m == 2) ? h : 8'h00;
    endfunction
    initial begin
        void'($urandom(13948));
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        v = 8'($urandom()) & 8'h7f;
        for (int m = 0; m < 3; m++) begin
            wr(ADDR_TIMER_MODE_REG, 8'(m));
            wr(ADDR_T0_HI, (m == 2) ? v : 8'hff);
            wr(ADDR_T0_LO, 8'hfc);
            wr(ADDR_TIMER_CONTROL_REG, 8'h10);
            wt(0);
            rd(ADDR_T0_HI, hi_after(m, v));
        end
        level[PIN_IRQA] <= 1'b0;
        wr(ADDR_TIMER_MODE_REG, 8'h08);
        wr(ADDR_T0_LO, 8'h1f);
        wr(ADDR_TIMER_CONTROL_REG, 8'h10);
        rd(ADDR_T0_LO, 8'h1f);
        wr(ADDR_CAP_HI, v);
        wr(ADDR_T2_HI, 8'hff);
        wr(ADDR_TIMER2_CONTROL, 8'h04);
        wt(1);
        rd(ADDR_T2_HI, v);
        wr(ADDR_TIMER2_CONTROL, 8'h14);
        wr(ADDR_T2_HI, 8'hff);
        wt(2);
        rd(ADDR_TIMER2_CONTROL, 8'h14);
        wr(ADDR_TIMER2_CONTROL, 8'h09);
        wr(ADDR_T2_LO, v);
        level[PIN_TRIG] <= 1'b0;
        wt(1);
        rd(ADDR_CAP_LO, v);
        stop_test(0);
    end
endmodule
`default_nettype wire
